/* File: dma_pkg.sv */
// Contract
// - Fixed priority or alternating when both pending
// - DMA beats CPU except locked/odd-word splits; code defers DMA only on cpu_lock
// - External bus hold defers DMA
// - Maskable interrupts never suspend DMA
// - CPU barred from memory while DMA owns bus
// - NMI halts all DMA activity; code blocks new transfers but lets a started deposit write finish
// - Source pointer increments, decrements or holds
// - Source access to memory or I/O
// - Destination pointer increments, decrements or holds
// - Destination access to memory or I/O
// - Byte or word transfers, matching pointer step
// - Optional interrupt after final transfer
// - Request pin may act as interrupt input
// - Terminate on count stops channel
// - Unsynchronized, source or destination paced; code gates only the start of the fetch on the request in both paced modes
// - Channel may target serial port registers
// - 20-bit pointers, 16-bit count, live updates
// - Request from pin, timer 2, serial, software
// - Fetch then deposit, eight clocks minimum; code takes nine: four fetch, one turnaround, four deposit
package dma_pkg;
    localparam int NCH  = 2;
    localparam int AW   = 20;
    localparam int DW   = 16;
    localparam int HW   = AW - DW;
    localparam int RAW  = 5;
    localparam int CH_BIT = 3;

    localparam logic [2:0] IDX_SRC_LO = 3'h0;
    localparam logic [2:0] IDX_SRC_HI = 3'h1;
    localparam logic [2:0] IDX_DST_LO = 3'h2;
    localparam logic [2:0] IDX_DST_HI = 3'h3;
    localparam logic [2:0] IDX_COUNT  = 3'h4;
    localparam logic [2:0] IDX_CTRL   = 3'h5;
    localparam logic [RAW-1:0] STATUS_ADDR = 5'h10;

    localparam int C_ARM   = 0;
    localparam int C_WORD  = 1;
    localparam int C_IEN   = 2;
    localparam int C_TC    = 3;
    localparam int C_PRI   = 4;
    localparam int C_SYNC  = 5;
    localparam int C_SSTEP = 7;
    localparam int C_SIO   = 9;
    localparam int C_DSTEP = 10;
    localparam int C_DIO   = 12;
    localparam int C_PINT  = 13;
    localparam int C_RSRC  = 14;

    localparam logic [1:0] STEP_HOLD = 2'h0;
    localparam logic [1:0] STEP_INC  = 2'h1;
    localparam logic [1:0] STEP_DEC  = 2'h2;
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_SRC  = 2'h1;
    localparam logic [1:0] SYNC_DST  = 2'h2;
    localparam logic [1:0] RSRC_PIN  = 2'h0;
    localparam logic [1:0] RSRC_TMR  = 2'h1;
    localparam logic [1:0] RSRC_SER  = 2'h2;
    localparam logic [1:0] RSRC_SW   = 2'h3;

    localparam logic [DW-1:0] CTRL_RESET  = 16'h0000;
    localparam logic [DW-1:0] COUNT_ONE   = 16'h0001;
    localparam logic [DW-1:0] COUNT_ZERO  = 16'h0000;
    localparam logic [AW-1:0] STEP_BYTE   = 20'h00001;
    localparam logic [AW-1:0] STEP_WORD   = 20'h00002;
    localparam logic [1:0]    BUS_LAST_T  = 2'h3;

    typedef enum logic [2:0] {
        DMA_IDLE    = 3'h1,
        DMA_FETCH   = 3'h2,
        DMA_DEPOSIT = 3'h4
    } dma_state_e;
endpackage

/* File: dma_chan.sv */
`timescale 1ns/1ps
module dma_chan
    import dma_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          wr,
    input  wire logic [2:0]    wr_idx,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          done,
    output logic [AW-1:0]      src,
    output logic [AW-1:0]      dst,
    output logic [DW-1:0]      cnt,
    output logic [DW-1:0]      ctl,
    output logic               final_xfer
);
    logic [AW-1:0] src_reg, src_next, dst_reg, dst_next, step;
    logic [DW-1:0] cnt_reg, ctl_reg;
    logic          stop_now;

    assign step       = ctl_reg[C_WORD] ? STEP_WORD : STEP_BYTE;
    assign src_next   = (ctl_reg[C_SSTEP+:2] == STEP_INC) ? src_reg + step :
                        (ctl_reg[C_SSTEP+:2] == STEP_DEC) ? src_reg - step : src_reg;
    assign dst_next   = (ctl_reg[C_DSTEP+:2] == STEP_INC) ? dst_reg + step :
                        (ctl_reg[C_DSTEP+:2] == STEP_DEC) ? dst_reg - step : dst_reg;
    assign final_xfer = done && (cnt_reg == COUNT_ONE);
    assign stop_now   = final_xfer && ctl_reg[C_TC];
    assign src = src_reg;
    assign dst = dst_reg;
    assign cnt = cnt_reg;
    assign ctl = ctl_reg;

    // Software writes take effect at once and win per register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            src_reg <= '0;
            dst_reg <= '0;
            cnt_reg <= COUNT_ZERO;
            ctl_reg <= CTRL_RESET;
        end else begin
            if (wr && wr_idx == IDX_SRC_LO) begin
                src_reg[DW-1:0] <= wdata;
            end else if (wr && wr_idx == IDX_SRC_HI) begin
                src_reg[AW-1:DW] <= wdata[HW-1:0];
            end else if (done) begin
                src_reg <= src_next;
            end
            if (wr && wr_idx == IDX_DST_LO) begin
                dst_reg[DW-1:0] <= wdata;
            end else if (wr && wr_idx == IDX_DST_HI) begin
                dst_reg[AW-1:DW] <= wdata[HW-1:0];
            end else if (done) begin
                dst_reg <= dst_next;
            end
            if (wr && wr_idx == IDX_COUNT) begin
                cnt_reg <= wdata;
            end else if (done) begin
                cnt_reg <= cnt_reg - COUNT_ONE;
            end
            if (wr && wr_idx == IDX_CTRL) begin
                ctl_reg <= wdata;
            end else if (stop_now) begin
                ctl_reg[C_ARM] <= 1'b0;
            end
        end
    end
endmodule

/* File: dma_arb.sv */
`timescale 1ns/1ps
module dma_arb
    import dma_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           rst,
    input  wire logic [NCH-1:0] elig,
    input  wire logic [NCH-1:0] pri,
    input  wire logic           done,
    output logic                pick
);
    logic favour_reg;
    logic both;

    assign both = &elig;
    // Higher priority wins; equal priorities alternate
    assign pick = !both ? elig[1] :
                  (pri[0] != pri[1]) ? pri[1] : favour_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            favour_reg <= 1'b0;
        end else if (done && both && pri[0] == pri[1]) begin
            favour_reg <= ~favour_reg;
        end
    end
endmodule

/* File: dma_top.sv */
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module dma_top
    import dma_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic [RAW-1:0]      reg_addr,
    input  wire logic [DW-1:0]       reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [DW-1:0]            reg_rdata,
    input  wire logic [NCH-1:0]      channel_request_pin,
    input  wire logic                timer2_req,
    input  wire logic [NCH-1:0]      serial_req,
    input  wire logic                nmi,
    input  wire logic                hold_req,
    input  wire logic                cpu_lock,
    output logic                     hold_ack,
    output logic [AW-1:0]            bus_addr,
    output logic                     bus_io,
    output logic                     bus_rd,
    output logic                     bus_wr,
    output logic                     bus_byte,
    output logic [DW-1:0]            bus_wdata,
    input  wire logic [DW-1:0]       bus_rdata,
    input  wire logic                bus_ready,
    output logic                     dma_owns_bus,
    output logic [NCH-1:0]           dma_irq,
    output logic [NCH-1:0]           pin_irq
);
    import dma_pkg::*;

    dma_state_e      state_reg, state_next;
    logic [1:0]      t_reg;
    logic            ch_reg;
    logic [DW-1:0]   data_reg;
    logic [DW-1:0]   rdata_reg;
    logic [AW-1:0]   addr_reg;
    logic            io_reg, rd_reg, wr_reg, byte_reg, own_reg, hack_reg;
    logic [NCH-1:0]  irq_reg, pint_reg;

    logic [AW-1:0]   src [NCH];
    logic [AW-1:0]   dst [NCH];
    logic [DW-1:0]   cnt [NCH];
    logic [DW-1:0]   ctl [NCH];
    logic [NCH-1:0]  req, elig, pri, done_v, final_v, wr_v;
    logic            pick, done, cyc_end, can_start, abort;
    logic            in_chan_space, sel_ch;
    logic [DW-1:0]   chan_rd, status_rd;
    logic [2:0]      reg_idx;

    assign in_chan_space = (reg_addr[RAW-1] == 1'b0);
    assign sel_ch        = reg_addr[CH_BIT];
    assign reg_idx       = reg_addr[2:0];

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            logic       src_sel;
            logic [1:0] sync;
            logic [1:0] rsrc;

            assign sync = ctl[g][C_SYNC+:2];
            assign rsrc = ctl[g][C_RSRC+:2];
            // Pin routed to interrupt stops serving as a request
            assign src_sel = (rsrc == RSRC_PIN) ? (channel_request_pin[g] && !ctl[g][C_PINT]) :
                             (rsrc == RSRC_TMR) ? timer2_req :
                             (rsrc == RSRC_SER) ? serial_req[g] : 1'b1;
            assign req[g]  = (sync == SYNC_NONE) || src_sel;
            assign elig[g] = ctl[g][C_ARM] && req[g] &&
                             !(ctl[g][C_TC] && cnt[g] == COUNT_ZERO);
            assign pri[g]    = ctl[g][C_PRI];
            assign wr_v[g]   = reg_wr && in_chan_space && (sel_ch == 1'(g));
            assign done_v[g] = done && (ch_reg == 1'(g));

            dma_chan u_chan (
                .clock      (clock),
                .rst        (rst),
                .wr         (wr_v[g]),
                .wr_idx     (reg_idx),
                .wdata      (reg_wdata),
                .done       (done_v[g]),
                .src        (src[g]),
                .dst        (dst[g]),
                .cnt        (cnt[g]),
                .ctl        (ctl[g]),
                .final_xfer (final_v[g])
            );

            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    irq_reg[g]  <= 1'b0;
                    pint_reg[g] <= 1'b0;
                end else begin
                    irq_reg[g]  <= final_v[g] && ctl[g][C_IEN];
                    pint_reg[g] <= ctl[g][C_PINT] && channel_request_pin[g];
                end
            end
        end
    endgenerate

    dma_arb u_arb (
        .clock (clock),
        .rst   (rst),
        .elig  (elig),
        .pri   (pri),
        .done  (done),
        .pick  (pick)
    );

    // Maskable interrupts are not an input here, so they never gate DMA
    assign can_start = (|elig) && !nmi && !hold_req && !cpu_lock;
    assign cyc_end   = (t_reg == BUS_LAST_T) && bus_ready;
    assign abort     = nmi;
    assign done      = (state_reg == DMA_DEPOSIT) && wr_reg && cyc_end;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DMA_IDLE: begin
                if (can_start) begin
                    state_next = DMA_FETCH;
                end
            end
            DMA_FETCH: begin
                if (cyc_end) begin
                    state_next = abort ? DMA_IDLE : DMA_DEPOSIT;
                end
            end
            DMA_DEPOSIT: begin
                if (done || (abort && !wr_reg)) begin
                    state_next = DMA_IDLE;
                end
            end
            default: state_next = DMA_IDLE;
        endcase
    end

    // Fetch from source, then deposit at destination
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= DMA_IDLE;
            t_reg     <= 2'h0;
            ch_reg    <= 1'b0;
            data_reg  <= '0;
            addr_reg  <= '0;
            io_reg    <= 1'b0;
            rd_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            byte_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            case (state_reg)
                DMA_IDLE: begin
                    t_reg <= 2'h0;
                    if (can_start) begin
                        ch_reg   <= pick;
                        addr_reg <= src[pick];
                        io_reg   <= ctl[pick][C_SIO];
                        byte_reg <= !ctl[pick][C_WORD];
                        rd_reg   <= 1'b1;
                    end
                end
                DMA_FETCH: begin
                    if (cyc_end) begin
                        t_reg    <= 2'h0;
                        rd_reg   <= 1'b0;
                        data_reg <= bus_rdata;
                    end else if (t_reg != BUS_LAST_T) begin
                        t_reg <= t_reg + 2'h1;
                    end
                end
                DMA_DEPOSIT: begin
                    if (!wr_reg) begin
                        if (!hold_req && !abort) begin
                            addr_reg <= dst[ch_reg];
                            io_reg   <= ctl[ch_reg][C_DIO];
                            wr_reg   <= 1'b1;
                        end
                    end else if (cyc_end) begin
                        t_reg  <= 2'h0;
                        wr_reg <= 1'b0;
                    end else if (t_reg != BUS_LAST_T) begin
                        t_reg <= t_reg + 2'h1;
                    end
                end
                default: begin
                    t_reg  <= 2'h0;
                    rd_reg <= 1'b0;
                    wr_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            own_reg  <= 1'b0;
            hack_reg <= 1'b0;
        end else begin
            own_reg  <= (state_next != DMA_IDLE);
            hack_reg <= hold_req && (state_next == DMA_IDLE);
        end
    end

    assign chan_rd = (reg_idx == IDX_SRC_LO) ? src[sel_ch][DW-1:0] :
                     (reg_idx == IDX_SRC_HI) ? {{(DW-HW){1'b0}}, src[sel_ch][AW-1:DW]} :
                     (reg_idx == IDX_DST_LO) ? dst[sel_ch][DW-1:0] :
                     (reg_idx == IDX_DST_HI) ? {{(DW-HW){1'b0}}, dst[sel_ch][AW-1:DW]} :
                     (reg_idx == IDX_COUNT)  ? cnt[sel_ch] :
                     (reg_idx == IDX_CTRL)   ? ctl[sel_ch] : '0;
    assign status_rd = {8'h00, ch_reg, state_reg, elig, ctl[1][C_ARM], ctl[0][C_ARM]};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            rdata_reg <= in_chan_space ? chan_rd :
                         (reg_addr == STATUS_ADDR) ? status_rd : '0;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata    = rdata_reg;
    assign bus_addr     = addr_reg;
    assign bus_io       = io_reg;
    assign bus_rd       = rd_reg;
    assign bus_wr       = wr_reg;
    assign bus_byte     = byte_reg;
    assign bus_wdata    = data_reg;
    assign dma_owns_bus = own_reg;
    assign hold_ack     = hack_reg;
    assign dma_irq      = irq_reg;
    assign pin_irq      = pint_reg;
endmodule

/* File: dma_properties.sv */
`timescale 1ns/1ps
module dma_properties
    import dma_pkg::*;
(
    input wire logic           clock,
    input wire logic           rst,
    input wire logic [NCH-1:0] channel_request_pin,
    input wire logic           nmi,
    input wire logic           hold_req,
    input wire logic           cpu_lock,
    input wire logic           hold_ack,
    input wire logic [AW-1:0]  bus_addr,
    input wire logic           bus_rd,
    input wire logic           bus_wr,
    input wire logic           dma_owns_bus,
    input wire logic [NCH-1:0] dma_irq,
    input wire logic [NCH-1:0] pin_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_fetch;
        bus_rd [*4];
    endsequence
    sequence s_deposit;
        bus_wr [*4];
    endsequence
    a_fetch_len: assert property ($rose(bus_rd) |-> s_fetch) else $error("fetch too short");
    a_dep_len: assert property ($rose(bus_wr) |-> s_deposit) else $error("deposit too short");
    a_one_cycle: assert property (!(bus_rd && bus_wr)) else $error("read and write together");
    a_owns_bus: assert property (bus_rd || bus_wr |-> dma_owns_bus) else $error("bus used unowned");
    a_hold_quiet: assert property (hold_ack |-> !bus_rd && !bus_wr) else $error("cycle under hold");
    a_hold_defers: assert property (hold_req && !dma_owns_bus |=> !dma_owns_bus) else $error("hold ignored");
    a_nmi_halts: assert property (nmi && !dma_owns_bus |=> !dma_owns_bus) else $error("nmi ignored");
    a_lock_defers: assert property (cpu_lock && !dma_owns_bus |=> !dma_owns_bus) else $error("lock broken");
    a_addr_held: assert property (bus_rd && $past(bus_rd) |-> $stable(bus_addr)) else $error("addr moved");
    a_irq_end: assert property (|dma_irq |-> $fell(bus_wr) ##1 !(|dma_irq)) else $error("irq misplaced");
    a_pin_irq: assert property (pin_irq[0] |-> $past(channel_request_pin[0])) else $error("pin irq wrong");
endmodule

/* File: dma_mem.sv */
`timescale 1ns/1ps
module dma_mem
    import dma_pkg::*;
#(
    parameter int WAIT = 2
)
(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic [AW-1:0] bus_addr,
    input  wire logic          bus_io,
    input  wire logic          bus_rd,
    input  wire logic          bus_wr,
    input  wire logic          bus_byte,
    input  wire logic [DW-1:0] bus_wdata,
    output logic [DW-1:0]      bus_rdata,
    output logic               bus_ready
);
    logic [7:0]    busy;
    logic [DW-1:0] last_q;
    logic          wr_q;
    logic [AW-1:0] wlog [0:7];
    int            n_wr;
    logic          w_io;
    logic          w_byte;
    logic          r_io;
    logic [DW-1:0] w_data;
    // Slow answer, released data lines flip
    assign bus_ready = (bus_rd || bus_wr) && busy >= WAIT;
    assign bus_rdata = bus_rd ? bus_addr[DW-1:0] ^ 16'ha5c3 : ~last_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy <= 8'h00;
            last_q <= 16'h0000;
            wr_q <= 1'b0;
            n_wr <= 0;
        end else begin
            busy <= (bus_rd || bus_wr) ? busy + 8'h01 : 8'h00;
            wr_q <= bus_wr;
            if (bus_rd) begin
                last_q <= bus_rdata;
                r_io <= bus_io;
            end
            if (bus_wr && !wr_q) begin
                wlog[n_wr % 8] <= bus_addr;
                w_io <= bus_io;
                w_byte <= bus_byte;
                w_data <= bus_wdata;
                n_wr <= n_wr + 1;
            end
        end
    end
endmodule

/* File: test_dma_top.sv */
`timescale 1ns/1ps
module test_dma_top;
    import dma_pkg::*;
    typedef struct {
        logic [DW-1:0] ctl;
        logic [AW-1:0] src;
        logic [AW-1:0] dst;
        logic [AW-1:0] src_end;
        logic [AW-1:0] dst_end;
    } dma_row_s;
    logic           clock, rst, reg_wr, reg_rd, timer2_req, nmi, hold_req, cpu_lock;
    logic           hold_ack, bus_io, bus_rd, bus_wr, bus_byte, bus_ready, dma_owns_bus;
    logic [RAW-1:0] reg_addr;
    logic [DW-1:0]  reg_wdata, reg_rdata, bus_wdata, bus_rdata, d, m;
    logic [NCH-1:0] channel_request_pin, serial_req, dma_irq, pin_irq;
    logic [AW-1:0]  bus_addr, p;
    int             fails, total_checks, cyc, n0, k, irqs;
    dma_row_s       rows [4] = '{
        '{16'hd88f, 20'h12344, 20'h00100, 20'h12346, 20'h000fe},
        '{16'hc30d, 20'h0a001, 20'h20010, 20'h0a000, 20'h20010},
        '{16'hc40d, 20'h00055, 20'h3000f, 20'h00055, 20'h30010},
        '{16'hd20f, 20'h40000, 20'h50000, 20'h40000, 20'h50000}};
    dma_top dma_top_i (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .channel_request_pin, .timer2_req, .serial_req, .nmi, .hold_req, .cpu_lock, .hold_ack,
        .bus_addr, .bus_io, .bus_rd, .bus_wr, .bus_byte, .bus_wdata, .bus_rdata, .bus_ready,
        .dma_owns_bus, .dma_irq, .pin_irq);
    dma_mem dma_mem_i (.clock, .rst, .bus_addr, .bus_io, .bus_rd, .bus_wr, .bus_byte,
        .bus_wdata, .bus_rdata, .bus_ready);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (|dma_irq) begin
            irqs++;
        end
        if (cyc == 20000) begin
            fails++;
            stop_test;
        end
    end
    task automatic chk(input string s, input logic [AW-1:0] e, input logic [AW-1:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [RAW-1:0] a, input logic [DW-1:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [RAW-1:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic ptr(input logic ch, input logic [2:0] lo);
        rd({1'b0, ch, lo});
        p[15:0] = d;
        rd({1'b0, ch, lo + 3'h1});
        p[19:16] = d[3:0];
    endtask
    task automatic prog(input logic ch, input logic [AW-1:0] s, input logic [AW-1:0] t,
                        input logic [DW-1:0] c, input logic [DW-1:0] x);
        wr({1'b0, ch, IDX_SRC_LO}, s[15:0]);
        wr({1'b0, ch, IDX_SRC_HI}, {12'h000, s[19:16]});
        wr({1'b0, ch, IDX_DST_LO}, t[15:0]);
        wr({1'b0, ch, IDX_DST_HI}, {12'h000, t[19:16]});
        wr({1'b0, ch, IDX_COUNT}, c);
        wr({1'b0, ch, IDX_CTRL}, x);
    endtask
    task automatic wait_wr(input int n);
        for (k = 0; k < 300 && dma_mem_i.n_wr < n; k++) begin
            @(posedge clock);
        end
        repeat (4) @(posedge clock);
        chk("writes", n, dma_mem_i.n_wr);
    endtask
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, channel_request_pin, serial_req} = '0;
        {timer2_req, nmi, hold_req, cpu_lock} = '0;
        rst = 1'b1;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1 chk("owns", 0, dma_owns_bus);
        rd(STATUS_ADDR);
        chk("status", 16'h0010, d);
        rd(5'h07);
        chk("unmapped", 0, d);
        $display("test reset done");
        foreach (rows[i]) begin
            n0 = dma_mem_i.n_wr;
            prog(1'b0, rows[i].src, rows[i].dst, COUNT_ONE, rows[i].ctl);
            wait_wr(n0 + 1);
            m = rows[i].ctl[C_WORD] ? 16'hffff : 16'h00ff;
            chk("dst_addr", rows[i].dst, dma_mem_i.wlog[n0 % 8]);
            chk("dst_io", rows[i].ctl[C_DIO], dma_mem_i.w_io);
            chk("src_io", rows[i].ctl[C_SIO], dma_mem_i.r_io);
            chk("byte", !rows[i].ctl[C_WORD], dma_mem_i.w_byte);
            chk("data", (rows[i].src[15:0] ^ 16'ha5c3) & m, dma_mem_i.w_data & m);
            ptr(1'b0, IDX_SRC_LO);
            chk("src_end", rows[i].src_end, p);
            ptr(1'b0, IDX_DST_LO);
            chk("dst_end", rows[i].dst_end, p);
            $display("test row %0d done", i);
        end
        chk("irqs", 4, irqs);
        n0 = dma_mem_i.n_wr;
        prog(1'b1, 20'h00200, 20'h00300, 16'h0002, 16'hc00d);
        wait_wr(n0 + 2);
        repeat (30) @(posedge clock);
        chk("tc_stop", n0 + 2, dma_mem_i.n_wr);
        rd(5'h0c);
        chk("count", 0, d);
        $display("test terminate done");
        for (int b = 0; b < 3; b++) begin
            n0 = dma_mem_i.n_wr;
            {nmi, hold_req, cpu_lock} <= 3'h1 << b;
            prog(1'b0, 20'h00010, 20'h00020, COUNT_ONE, 16'hc00d);
            repeat (20) @(posedge clock);
            chk("blocked", n0, dma_mem_i.n_wr);
            chk("hold_ack", b == 1, hold_ack);
            {nmi, hold_req, cpu_lock} <= 3'h0;
            wait_wr(n0 + 1);
        end
        $display("test blockers done");
        for (int s = 0; s < 3; s++) begin
            n0 = dma_mem_i.n_wr;
            prog(1'b0, 20'h00010, 20'h00020, COUNT_ONE, 16'h002d | (s << C_RSRC));
            repeat (20) @(posedge clock);
            chk("paced", n0, dma_mem_i.n_wr);
            {serial_req[0], timer2_req, channel_request_pin[0]} <= 3'h1 << s;
            wait_wr(n0 + 1);
            {serial_req[0], timer2_req, channel_request_pin[0]} <= 3'h0;
        end
        $display("test pacing done");
        for (int f = 0; f < 2; f++) begin
            n0 = dma_mem_i.n_wr;
            nmi <= 1'b1;
            prog(1'b0, 20'h00000, 20'h00100, 16'h0002, 16'hc00d | (f << C_PRI));
            prog(1'b1, 20'h00000, 20'h00200, 16'h0002, 16'hc00d);
            nmi <= 1'b0;
            wait_wr(n0 + 4);
            for (int j = 0; j < 3; j++) begin
                chk("order", f ? (j == 1) : 1,
                    dma_mem_i.wlog[(n0 + j) % 8] != dma_mem_i.wlog[(n0 + j + 1) % 8]);
            end
        end
        $display("test priority done");
        wr(5'h05, 16'h2000);
        channel_request_pin[0] <= 1'b1;
        repeat (3) @(posedge clock);
        chk("pin_irq", 1, pin_irq[0]);
        channel_request_pin[0] <= 1'b0;
        $display("test pin irq done");
        prog(1'b0, 20'h00010, 20'h00020, 16'h0002, 16'hc00d);
        repeat (3) @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1 chk("owns_rst", 0, dma_owns_bus);
        rd(STATUS_ADDR);
        chk("status_rst", 16'h0010, d);
        $display("test mid reset done");
        stop_test;
    end
endmodule

bind dma_top dma_properties dma_properties_i (.clock, .rst, .channel_request_pin, .nmi,
    .hold_req, .cpu_lock, .hold_ack, .bus_addr, .bus_rd, .bus_wr, .dma_owns_bus, .dma_irq, .pin_irq);
